// ---- ppm_pixel_port.sv ----
// Functional notes
// - Colour inputs are captured on each rising edge of the latch strobe.
// - Sync, blank and palette select are captured on that same strobe edge.
// - After capture, pixels move through the pipeline on the pixel clock.
// - Strobe must be frequency locked only; any phase against the clock works.
// - Strobe output frequency follows the selected multiplex rate automatically.
// - Blank forces blanking level, sync forces sync level, per pixel.
// - Green sync encoding is on only while the encode bit is one.
// - Enabled timing pulse output carries the same delay as pixel data.
// - Each pixel's two select bits must equal the match code to select.
// - A non-matching pixel forces all three colour outputs to zero.
// - Select bits are demultiplexed exactly like the colour data.
// - Ninety-six colour inputs form four 24-bit pixel words.
// - 24-bit, 15-bit and 8-bit formats work in every multiplex mode.
// - In 1:1 mode the strobe is the pixel clock; data taken every cycle.
// - In 1:1 mode the clock still makes divided clock; strobe out is held high.
// - The port runs from reset with only the pixel clock applied.
// - A two-bit multiplex field selects the rate and strobe frequency.
// - Missed strobe timing costs extra delay: four, two or zero clocks.
// - Calibration runs on step one then step two, or each frame.
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_pixel_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pixel_latch_strobe_in_i,
  input wire logic [95:0] pixel_color_i,
  input wire logic [3:0] pixel_sync_n_i,
  input wire logic [3:0] pixel_blank_n_i,
  input wire logic [7:0] palette_select_in_i,
  input wire logic vertical_sync_i,
  output logic latch_strobe_out_o,
  output logic divided_clock_out_o,
  output logic timing_pulse_out_n_o,
  output logic [23:0] pix_data_o,
  output logic pix_valid_o,
  output logic pix_blank_o,
  output logic pix_green_sync_o,
  output logic pix_dac_off_o
);
  import ppm_pkg::*;

  logic [`PPM_CTRL_W-1:0] ctrl;
  logic cal_step1;
  logic cal_step2;
  ppm_mux_t mux;
  ppm_fmt_t fmt;
  logic is1;
  logic is2;
  logic is4;
  logic green_enc;
  logic tout_en;
  logic cal_frame;
  logic [1:0] match_code;
  logic [1:0] phase;
  logic [2:0] ratio;
  logic [23:0] fmt_mask;

  logic strobe_q;
  logic vsync_q;
  logic take;
  logic vs_rise;
  logic [95:0] cap_color;
  logic [3:0] cap_sync_n;
  logic [3:0] cap_blank_n;
  logic [7:0] cap_ps;
  logic cap_full;
  logic [3:0] lane_sel;
  logic load_now;

  logic [95:0] sh_color;
  logic [3:0] sh_sync_n;
  logic [3:0] sh_blank_n;
  logic [3:0] sh_sel;
  logic [2:0] sh_left;
  logic [95:0] base_color;
  logic [3:0] base_sync_n;
  logic [3:0] base_blank_n;
  logic [3:0] base_sel;
  logic [2:0] next_left;

  logic src_valid;
  logic [23:0] src_color;
  logic src_sync_n;
  logic src_blank_n;
  logic src_sel;

  ppm_cal_t cal_state;
  ppm_cal_t next_cal_state;
  logic [1:0] load_phase;
  logic [1:0] next_load_phase;
  logic calibrated;
  logic cal_done;

  ppm_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .status_i({cal_state != PPM_CAL_IDLE, load_phase, calibrated}),
    .ctrl_o(ctrl),
    .cal_step1_o(cal_step1),
    .cal_step2_o(cal_step2)
  );

  // The strobe divider runs from reset, so loop-back works with no setup.
  ppm_strobe_gen u_strobe (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mux_i(mux),
    .div_sel_i(ctrl[`PPM_CTRL_DIV_HI:`PPM_CTRL_DIV_LO]),
    .phase_o(phase),
    .latch_strobe_out_o(latch_strobe_out_o),
    .divided_clock_out_o(divided_clock_out_o)
  );

  assign mux = ppm_mux_t'(ctrl[`PPM_CTRL_MUX_HI:`PPM_CTRL_MUX_LO]);
  assign fmt = ppm_fmt_t'(ctrl[`PPM_CTRL_FMT_HI:`PPM_CTRL_FMT_LO]);
  assign is1 = mux == PPM_MUX_1TO1;
  assign is2 = mux == PPM_MUX_2TO1;
  assign is4 = ~is1 & ~is2;
  assign green_enc = ctrl[`PPM_CTRL_GRN_ENC];
  assign tout_en = ctrl[`PPM_CTRL_TOUT_EN];
  assign cal_frame = ctrl[`PPM_CTRL_CAL_FRAME];
  assign match_code = ctrl[`PPM_CTRL_MATCH_HI:`PPM_CTRL_MATCH_LO];
  assign ratio = is4 ? 3'h4 : is2 ? 3'h2 : 3'h1;
  // Narrow formats keep only the bits that the palette index uses.
  assign fmt_mask = (fmt == PPM_FMT_24) ? `PPM_MASK_24 :
                    (fmt == PPM_FMT_15) ? `PPM_MASK_15 : `PPM_MASK_8;

  // In 1:1 the strobe is the clock itself, so every cycle carries a new pixel.
  assign take = is1 | (pixel_latch_strobe_in_i & ~strobe_q);
  assign vs_rise = vertical_sync_i & ~vsync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_q <= 1'b0;
      vsync_q <= 1'b0;
    end else begin
      strobe_q <= pixel_latch_strobe_in_i;
      vsync_q <= vertical_sync_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_color <= 96'h0000_0000_0000_0000_0000_0000;
      cap_sync_n <= 4'hF;
      cap_blank_n <= 4'hF;
      cap_ps <= 8'h00;
    end else if (take) begin
      cap_color <= pixel_color_i;
      cap_sync_n <= pixel_sync_n_i;
      cap_blank_n <= pixel_blank_n_i;
      cap_ps <= palette_select_in_i;
    end
  end

  // A fresh capture sets the flag even in the cycle that drains the old word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_full <= 1'b0;
    end else begin
      cap_full <= take | (cap_full & ~load_now);
    end
  end

  for (genvar k = 0; k < `PPM_LANES; k++) begin : g_lane
    assign lane_sel[k] = cap_ps[2*k+1:2*k] == match_code;
  end

  // The word moves to the serializer only in its calibrated slot, or in the next cycle in 1:1 mode;
  // a strobe that lands just after the slot waits a full word time, which is the extra delay.
  assign load_now = cap_full & (is1 | (phase == load_phase));

  assign base_color = load_now ? cap_color : sh_color;
  assign base_sync_n = load_now ? cap_sync_n : sh_sync_n;
  assign base_blank_n = load_now ? cap_blank_n : sh_blank_n;
  assign base_sel = load_now ? lane_sel : sh_sel;
  assign next_left = load_now ? ratio - 3'h1 : (sh_left != 3'h0) ? sh_left - 3'h1 : 3'h0;

  assign src_valid = load_now | (sh_left != 3'h0);
  assign src_color = base_color[23:0];
  assign src_sync_n = base_sync_n[0];
  assign src_blank_n = base_blank_n[0];
  assign src_sel = base_sel[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_color <= 96'h0000_0000_0000_0000_0000_0000;
      sh_sync_n <= 4'hF;
      sh_blank_n <= 4'hF;
      sh_sel <= 4'h0;
      sh_left <= 3'h0;
    end else begin
      sh_color <= {24'h00_0000, base_color[95:24]};
      sh_sync_n <= {1'b1, base_sync_n[3:1]};
      sh_blank_n <= {1'b1, base_blank_n[3:1]};
      sh_sel <= {1'b0, base_sel[3:1]};
      sh_left <= next_left;
    end
  end

  // Sync and blank ride the same stage as the pixel so their delay matches.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_valid_o <= 1'b0;
      pix_data_o <= 24'h00_0000;
      pix_blank_o <= 1'b0;
      pix_green_sync_o <= 1'b0;
      pix_dac_off_o <= 1'b0;
      timing_pulse_out_n_o <= 1'b1;
    end else begin
      pix_valid_o <= src_valid;
      pix_data_o <= (src_valid & src_sel) ? (src_color & fmt_mask) : 24'h00_0000;
      pix_blank_o <= src_valid & src_sel & ~src_blank_n;
      pix_green_sync_o <= src_valid & src_sel & green_enc & ~src_sync_n;
      pix_dac_off_o <= src_valid & ~src_sel;
      if (~tout_en) begin
        timing_pulse_out_n_o <= 1'b1;
      end else if (src_valid) begin
        timing_pulse_out_n_o <= src_sync_n;
      end
    end
  end

  assign cal_done = (cal_state == PPM_CAL_ARMED) & (is1 | (pixel_latch_strobe_in_i & ~strobe_q));
  assign next_load_phase = is2 ? {1'b0, ~phase[0]} : phase + 2'h1;

  always_comb begin
    next_cal_state = cal_state;
    case (cal_state)
      PPM_CAL_IDLE: begin
        if (cal_frame & vs_rise) begin
          next_cal_state = PPM_CAL_ARMED;
        end else if (cal_step1) begin
          next_cal_state = PPM_CAL_STEP;
        end
      end
      PPM_CAL_STEP: begin
        if (cal_step2) begin
          next_cal_state = PPM_CAL_ARMED;
        end
      end
      PPM_CAL_ARMED: begin
        if (cal_done) begin
          next_cal_state = PPM_CAL_IDLE;
        end
      end
      default: begin
        next_cal_state = PPM_CAL_IDLE;
      end
    endcase
  end

  // Calibration places the load slot one clock after the observed strobe edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_state <= PPM_CAL_IDLE;
      load_phase <= `PPM_LOAD_PHASE_RST;
      calibrated <= 1'b0;
    end else begin
      cal_state <= next_cal_state;
      if (cal_done) begin
        load_phase <= is1 ? 2'h0 : next_load_phase;
        calibrated <= 1'b1;
      end
    end
  end

  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
    (pixel_latch_strobe_in_i && !strobe_q) |=> (cap_color == $past(pixel_color_i)))
    else $error("Colour word not captured on strobe edge.");

  AST_CTRL_ALIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (pixel_latch_strobe_in_i && !strobe_q) |=>
      (cap_sync_n == $past(pixel_sync_n_i) && cap_blank_n == $past(pixel_blank_n_i)
       && cap_ps == $past(palette_select_in_i)))
    else $error("Control bits not captured with colour word.");

  AST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_now && is4) |=> (sh_color[23:0] == $past(cap_color[47:24]) && sh_left == 3'h3))
    else $error("Second lane not next in serializer.");

  AST_STROBE_RATE: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(latch_strobe_out_o) && is4 && $past(is4)) ##1 is4[*4] |-> $rose(latch_strobe_out_o))
    else $error("Strobe out period wrong in 4:1 mode.");

  AST_BLANK: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_valid && src_sel && !src_blank_n) |=> (pix_blank_o && pix_valid_o))
    else $error("Blank pixel not forced to blank level.");

  AST_GREEN_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !green_enc |=> !pix_green_sync_o)
    else $error("Green sync encoded while encode bit is zero.");

  AST_TIMING_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
    (tout_en && src_valid) |=> (timing_pulse_out_n_o == $past(src_sync_n)))
    else $error("Timing pulse out not aligned with pixel.");

  AST_DESELECT: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_valid && !src_sel) |=> (pix_dac_off_o && pix_data_o == 24'h00_0000 && !pix_blank_o
                                 && !pix_green_sync_o))
    else $error("Unselected pixel not shut down.");

  AST_ONE2ONE: assert property (@(posedge clk_i) disable iff (rst_i)
    is1 ##1 is1 |=> pix_valid_o)
    else $error("1:1 mode did not emit a pixel each clock.");

  AST_CALIBRATE: assert property (@(posedge clk_i) disable iff (rst_i)
    cal_done |=> (calibrated && cal_state == PPM_CAL_IDLE))
    else $error("Calibration did not complete.");

  AST_STROBE_RATE_2TO1: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(latch_strobe_out_o) && is2 && $past(is2)) ##1 is2[*2] |-> $rose(latch_strobe_out_o))
    else $error("Strobe out period wrong in 2:1 mode.");

  AST_ORDER_2TO1: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_now && is2) |=> (sh_color[23:0] == $past(cap_color[47:24]) && sh_left == 3'h1))
    else $error("Second lane not next in 2:1 mode.");

  AST_GREEN_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    (src_valid && src_sel && green_enc && !src_sync_n) |=> pix_green_sync_o)
    else $error("Green sync missing while encode bit is one.");

  AST_TIMING_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    !tout_en |=> timing_pulse_out_n_o)
    else $error("Timing pulse out active while disabled.");

  AST_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !src_valid |=> (!pix_valid_o && pix_data_o == 24'h00_0000 && !pix_blank_o && !pix_green_sync_o
                    && !pix_dac_off_o))
    else $error("Idle pixel stage not at zero.");
endmodule : ppm_pixel_port
`default_nettype wire

// ---- ppm_cfg.svh ----
`ifndef PPM_CFG_SVH
`define PPM_CFG_SVH
`define PPM_ADR_CTRL 8'h00
`define PPM_ADR_CAL 8'h04
`define PPM_ADR_STAT 8'h08
`define PPM_CTRL_MUX_LO 0
`define PPM_CTRL_MUX_HI 1
`define PPM_CTRL_GRN_ENC 2
`define PPM_CTRL_TOUT_EN 3
`define PPM_CTRL_CAL_FRAME 4
`define PPM_CTRL_MATCH_LO 5
`define PPM_CTRL_MATCH_HI 6
`define PPM_CTRL_DIV_LO 7
`define PPM_CTRL_DIV_HI 8
`define PPM_CTRL_FMT_LO 9
`define PPM_CTRL_FMT_HI 10
`define PPM_CTRL_W 11
`define PPM_CTRL_RST 11'h002
`define PPM_CAL_STEP1 0
`define PPM_CAL_STEP2 1
`define PPM_LOAD_PHASE_RST 2'h1
`define PPM_DIV_CNT_RST 5'h1F
`define PPM_MASK_24 24'hFF_FFFF
`define PPM_MASK_15 24'hF8_F8F8
`define PPM_MASK_8 24'h00_00FF
`define PPM_PIX_W 24
`define PPM_LANES 4
`endif

// ---- ppm_pkg.sv ----
package ppm_pkg;
  typedef enum logic [1:0] {PPM_MUX_1TO1, PPM_MUX_2TO1, PPM_MUX_4TO1, PPM_MUX_4TO1_ALT} ppm_mux_t;
  typedef enum logic [1:0] {PPM_FMT_24, PPM_FMT_15, PPM_FMT_8, PPM_FMT_8_ALT} ppm_fmt_t;
  typedef enum logic [1:0] {PPM_CAL_IDLE, PPM_CAL_STEP, PPM_CAL_ARMED} ppm_cal_t;
endpackage : ppm_pkg

// ---- ppm_strobe_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_strobe_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ppm_pkg::ppm_mux_t mux_i,
  input wire logic [1:0] div_sel_i,
  output logic [1:0] phase_o,
  output logic latch_strobe_out_o,
  output logic divided_clock_out_o
);
  import ppm_pkg::*;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic next_strobe;
  logic next_div;
  assign next_cnt = cnt + 5'h01;
  // Both outputs rise when the low counter bits wrap, so their rising edges coincide.
  assign next_strobe = (mux_i == PPM_MUX_2TO1) ? ~next_cnt[0] :
                       (mux_i == PPM_MUX_1TO1) ? 1'b1 : ~next_cnt[1];
  // The index is widened so that the slowest divider setting does not wrap onto bit zero.
  assign next_div = ~next_cnt[{1'b0, div_sel_i} + 3'h1];
  assign phase_o = (mux_i == PPM_MUX_2TO1) ? {1'b0, cnt[0]} :
                   (mux_i == PPM_MUX_1TO1) ? 2'h0 : cnt[1:0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // All ones matches the low outputs held in reset, so the first high phase after release is a full one.
      cnt <= `PPM_DIV_CNT_RST;
      latch_strobe_out_o <= 1'b0;
      divided_clock_out_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      latch_strobe_out_o <= next_strobe;
      divided_clock_out_o <= next_div;
    end
  end
endmodule : ppm_strobe_gen
`default_nettype wire

// ---- ppm_wb_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_wb_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] status_i,
  output logic [`PPM_CTRL_W-1:0] ctrl_o,
  output logic cal_step1_o,
  output logic cal_step2_o
);
  import ppm_pkg::*;
  logic req;
  logic wr;
  logic hit_ctrl;
  logic hit_cal;
  logic hit_stat;
  logic [31:0] next_rdat;
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack, as the bus expects.
  assign wr = req & wb_we_i & wb_ack_o;
  assign hit_ctrl = wb_adr_i == `PPM_ADR_CTRL;
  assign hit_cal = wb_adr_i == `PPM_ADR_CAL;
  assign hit_stat = wb_adr_i == `PPM_ADR_STAT;
  assign next_rdat = hit_ctrl ? {21'h00_0000, ctrl_o} :
                     hit_stat ? {28'h000_0000, status_i} : 32'h0000_0000;
  assign cal_step1_o = wr & hit_cal & wb_sel_i[0] & wb_dat_i[`PPM_CAL_STEP1];
  assign cal_step2_o = wr & hit_cal & wb_sel_i[0] & wb_dat_i[`PPM_CAL_STEP2];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_o <= `PPM_CTRL_RST;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= next_rdat;
      end
      if (wr & hit_ctrl & wb_sel_i[0]) begin
        ctrl_o[7:0] <= wb_dat_i[7:0];
      end
      if (wr & hit_ctrl & wb_sel_i[1]) begin
        ctrl_o[`PPM_CTRL_W-1:8] <= wb_dat_i[`PPM_CTRL_W-1:8];
      end
    end
  end
endmodule : ppm_wb_regs
`default_nettype wire

// ---- ppm_fb_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppm_fb_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic each_i,
  input wire logic go_i,
  output logic took_o,
  output logic [7:0] word_o,
  output logic [95:0] color_o,
  output logic [3:0] sync_n_o,
  output logic [3:0] blank_n_o,
  output logic [7:0] select_o
);
  logic load_q;
  // The next word is shown only after the edge that took the old one, so data is steady across a strobe period.
  assign took_o = go_i && !rst_i && (each_i || (load_i && !load_q));
  always_ff @(posedge clk_i) begin
    load_q <= load_i;
    if (!go_i) begin
      word_o <= 8'h00;
    end else if (took_o) begin
      word_o <= word_o + 8'h01;
    end
  end
  // Every lane carries its word and lane number, so a swapped or repeated lane shows up in the data.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      color_o[24*k+:24] = {word_o, 6'h00, 2'(k), ~word_o};
      select_o[2*k+:2] = word_o[1:0] + 2'(k);
      blank_n_o[k] = word_o[k+1];
      sync_n_o[k] = word_o[k+2];
    end
  end
endmodule : ppm_fb_model
`default_nettype wire

// ---- ppm_pixel_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ppm_cfg.svh"
module ppm_pixel_port_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack, lso, dco, tpo_n, pvalid, pblank, pgreen, poff, took;
  logic [23:0] pdata;
  logic vsync = 1'b0;
  logic go = 1'b0;
  logic each = 1'b0;
  logic checking = 1'b0;
  logic [7:0] word, psel;
  logic [95:0] color;
  logic [3:0] sn, bn;
  logic [1:0] match;
  logic enc, tout;
  logic [23:0] mask;
  logic [9:0] q[$];
  int mismatches = 0;
  int tests_run = 0;
  int skip = 0;
  int lanes = 4;

  always #5 clk_i = ~clk_i;

  ppm_pixel_port i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .pixel_latch_strobe_in_i(lso), .pixel_color_i(color), .pixel_sync_n_i(sn), .pixel_blank_n_i(bn),
    .palette_select_in_i(psel), .vertical_sync_i(vsync), .latch_strobe_out_o(lso),
    .divided_clock_out_o(dco), .timing_pulse_out_n_o(tpo_n), .pix_data_o(pdata), .pix_valid_o(pvalid),
    .pix_blank_o(pblank), .pix_green_sync_o(pgreen), .pix_dac_off_o(poff)
  );

  ppm_fb_model i_fb (
    .clk_i(clk_i), .rst_i(rst_i), .load_i(lso), .each_i(each), .go_i(go), .took_o(took),
    .word_o(word), .color_o(color), .sync_n_o(sn), .blank_n_o(bn), .select_o(psel)
  );

  task results;
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wdat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      results();
    end
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb_xfer(1'b1, a, d, x);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    wb_xfer(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  task rises(input int n, output int a, output int b);
    logic pa, pb;
    a = 0;
    b = 0;
    pa = lso;
    pb = dco;
    repeat (n) begin
      @(posedge clk_i);
      if (lso === 1'b1 && pa === 1'b0) a++;
      if (dco === 1'b1 && pb === 1'b0) b++;
      pa = lso;
      pb = dco;
    end
  endtask : rises

  // Each taken word queues its lanes; the first one is due two edges after capture.
  always @(posedge clk_i) begin
    logic [9:0] e;
    logic s, b_n, s_n;
    if (checking) begin
      if (q.size() > 0 && skip > 0) begin
        skip--;
      end else if (q.size() > 0) begin
        e = q.pop_front();
        s = (e[3:2] + e[1:0]) == match;
        b_n = e[3 + int'(e[1:0])];
        s_n = e[4 + int'(e[1:0])];
        check("pix_valid", 1, pvalid);
        check("pix_data", s ? {e[9:2], 6'h00, e[1:0], ~e[9:2]} & mask : 24'h00_0000, pdata);
        check("pix_dac_off", !s, poff);
        check("pix_blank", s & ~b_n, pblank);
        check("pix_green_sync", s & enc & ~s_n, pgreen);
        if (s) check("timing_pulse_out_n", tout ? s_n : 1'b1, tpo_n);
      end
      if (took) for (int k = 0; k < lanes; k++) q.push_back({word, 2'(k)});
    end
  end

  task stream(input logic [1:0] m, input logic [1:0] f);
    match = m + f;
    enc = f[0] ^ m[0];
    tout = ~enc;
    mask = f == 2'd0 ? `PPM_MASK_24 : f == 2'd1 ? `PPM_MASK_15 : `PPM_MASK_8;
    lanes = m == 2'd0 ? 1 : m == 2'd1 ? 2 : 4;
    wr(`PPM_ADR_CTRL, {21'h0, f, 2'b00, match, 1'b0, tout, enc, m});
    each <= (m == 2'd0);
    repeat (12) @(posedge clk_i);
    q.delete();
    skip = 1;
    go <= 1'b1;
    checking <= 1'b1;
    repeat (40) @(posedge clk_i);
    go <= 1'b0;
    repeat (6) @(posedge clk_i);
    checking <= 1'b0;
    @(posedge clk_i);
  endtask : stream

  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    logic [31:0] d;
    int a, b;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    check("timing_pulse_out_n", 1, tpo_n);
    check("pix_valid", 0, pvalid);
    @(posedge clk_i);
    rises(32, a, b);
    check("latch_strobe_out rises", 8, a);
    rd(`PPM_ADR_CTRL, d);
    check("ctrl", 32'h0000_0002, d);
    rd(`PPM_ADR_STAT, d);
    check("stat", 32'h0000_0002, d);
    rd(`PPM_ADR_CAL, d);
    check("cal", 32'h0000_0000, d);
    rd(8'h0C, d);
    check("unmapped", 32'h0000_0000, d);
    for (int f = 0; f < 3; f++) for (int m = 0; m < 3; m++) stream(2'(m), 2'(f));
    for (int m = 0; m < 3; m++) begin
      wr(`PPM_ADR_CTRL, 32'(m));
      repeat (8) @(posedge clk_i);
      rises(32, a, b);
      check("latch_strobe_out rises", m == 0 ? 0 : m == 1 ? 16 : 8, a);
    end
    // The divider is checked in 1:1 mode, where the strobe input no longer paces the block.
    for (int dv = 0; dv < 4; dv++) begin
      wr(`PPM_ADR_CTRL, 32'(dv) << 7);
      repeat (40) @(posedge clk_i);
      rises(64, a, b);
      check("divided_clock_out rises", 16 >> dv, b);
    end
    check("latch_strobe_out", 1, lso);
    wr(`PPM_ADR_CTRL, 32'h0000_0012);
    vsync <= 1'b1;
    repeat (3) @(posedge clk_i);
    vsync <= 1'b0;
    repeat (20) @(posedge clk_i);
    rd(`PPM_ADR_STAT, d);
    check("calibrated", 1, d[0]);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`PPM_ADR_STAT, d);
    check("calibrated", 0, d[0]);
    wr(`PPM_ADR_CAL, 32'h0000_0001);
    wr(`PPM_ADR_CAL, 32'h0000_0002);
    repeat (20) @(posedge clk_i);
    rd(`PPM_ADR_STAT, d);
    check("calibrated", 1, d[0]);
    results();
  end
endmodule : ppm_pixel_port_test
`default_nettype wire
